// [fwf_defines.svh]
`ifndef FWF_DEFINES_SVH
`define FWF_DEFINES_SVH

// ============================================================
// widths and depth
`define FWF_WORD_W      36
`define FWF_ADDR_W      10
`define FWF_CNT_W       11
`define FWF_OFF_W       10
`define FWF_LSB_W       8
`define FWF_MSB_W       2
`define FWF_SER_W       20
`define FWF_SYNC_W      46

// ============================================================
// occupancy marks
`define FWF_DEPTH       11'h400
`define FWF_CAP         11'h401
`define FWF_HALF_MARK   11'h202
`define FWF_AE_GAP      11'h002
`define FWF_ONE         11'h001

// ============================================================
// offset access sequence: empty lsb, empty msb, full lsb, full msb
`define FWF_SEL_E_LSB   2'h0
`define FWF_SEL_E_MSB   2'h1
`define FWF_SEL_F_LSB   2'h2
`define FWF_SEL_F_MSB   2'h3

// ============================================================
// default offsets picked at master reset; FWF_RST_OFF is loaded at system reset
`define FWF_OFF_511     10'h1ff
`define FWF_OFF_255     10'h0ff
`define FWF_OFF_127     10'h07f
`define FWF_OFF_63      10'h03f
`define FWF_OFF_31      10'h01f
`define FWF_OFF_15      10'h00f
`define FWF_OFF_7       10'h007
`define FWF_OFF_3       10'h003
`define FWF_RST_OFF     10'h07f

`endif

// [fwf_pkg.sv]
`include "fwf_defines.svh"

package fwf_pkg;
    // ============================================================
    // shared types
    typedef logic [`FWF_WORD_W-1:0] fwf_word_type;
    typedef logic [`FWF_OFF_W-1:0]  fwf_off_type;
    typedef logic [`FWF_CNT_W-1:0]  fwf_cnt_type;
    typedef logic [`FWF_ADDR_W-1:0] fwf_addr_type;
endpackage : fwf_pkg

// [fwf_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwf_defines.svh"

module fwf_sync
    import fwf_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic [`FWF_SYNC_W-1:0] i_async,
    output logic      [`FWF_SYNC_W-1:0] o_sync
);
    // ============================================================
    // two-stage synchroniser; first stage feeds only the second
    logic [`FWF_SYNC_W-1:0] meta_ff;
    logic [`FWF_SYNC_W-1:0] hold_ff;

    // pins pass together, keeping data aligned to clock pins
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= i_async;
            hold_ff <= meta_ff;
        end
    end

    assign o_sync = hold_ff;
endmodule : fwf_sync
`default_nettype wire

// [fwf_offset_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwf_defines.svh"

module fwf_offset_regs
    import fwf_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_mrs_active,
    input  wire logic         i_ld,
    input  wire logic         i_pick1,
    input  wire logic         i_pick0,
    input  wire logic         i_w_evt,
    input  wire logic         i_r_evt,
    input  wire logic         i_wen_n,
    input  wire logic         i_ren_n,
    input  wire logic         i_sen_n,
    input  wire logic         i_si,
    input  wire fwf_word_type i_data,
    output fwf_off_type       o_empty_off,
    output fwf_off_type       o_full_off,
    output fwf_word_type      o_rd_word
);
    // ============================================================
    // default offset table for the 1,024-deep array
    function automatic fwf_off_type fwf_default(input logic ld, input logic p1, input logic p0);
        fwf_off_type v;
        v = `FWF_OFF_127;
        unique case ({ld, p1, p0})
            3'h2: v = `FWF_OFF_511;
            3'h1: v = `FWF_OFF_255;
            3'h0: v = `FWF_OFF_127;
            3'h3: v = `FWF_OFF_63;
            3'h4: v = `FWF_OFF_31;
            3'h6: v = `FWF_OFF_15;
            3'h5: v = `FWF_OFF_7;
            3'h7: v = `FWF_OFF_3;
        endcase
        return v;
    endfunction : fwf_default

    logic        serial_ff;
    fwf_off_type empty_ff;
    fwf_off_type full_ff;
    logic [1:0]  wsel_ff;
    logic [1:0]  rsel_ff;
    logic        par_wr;
    logic        par_rd;
    logic        ser_shift;

    // offset access only while the load select is low
    assign par_wr    = i_w_evt & ~i_ld & ~i_wen_n & ~serial_ff;
    assign par_rd    = i_r_evt & ~i_ld & ~i_ren_n;                  // [RULE_15]
    assign ser_shift = i_w_evt & ~i_ld & i_wen_n & ~i_sen_n & serial_ff;

    // ============================================================
    // load method, caught while master reset is held
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            serial_ff <= 1'b0;
        end else if (i_mrs_active) begin
            serial_ff <= i_ld;                                      // [RULE_14]
        end
    end

    // ============================================================
    // offset values: defaults at reset, then parallel or serial loading
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            empty_ff <= `FWF_RST_OFF;
            full_ff  <= `FWF_RST_OFF;
        end else if (i_mrs_active) begin
            // deeper arrays need another table
            empty_ff <= fwf_default(i_ld, i_pick1, i_pick0);        // [RULE_12] [RULE_13]
            full_ff  <= fwf_default(i_ld, i_pick1, i_pick0);
        end else if (ser_shift) begin
            // first bit lands at empty lsb after all bits are in
            {full_ff, empty_ff} <= {i_si, full_ff, empty_ff[`FWF_OFF_W-1:1]}; // [RULE_19]
        end else if (par_wr) begin
            unique case (wsel_ff)                                   // [RULE_18] [RULE_16]
                `FWF_SEL_E_LSB: empty_ff[`FWF_LSB_W-1:0] <= i_data[`FWF_LSB_W-1:0];
                `FWF_SEL_E_MSB: empty_ff[`FWF_OFF_W-1:`FWF_LSB_W] <= i_data[`FWF_MSB_W-1:0];
                `FWF_SEL_F_LSB: full_ff[`FWF_LSB_W-1:0] <= i_data[`FWF_LSB_W-1:0];
                `FWF_SEL_F_MSB: full_ff[`FWF_OFF_W-1:`FWF_LSB_W] <= i_data[`FWF_MSB_W-1:0];
            endcase
        end
    end

    // ============================================================
    // write and read sequence pointers wrap after the fourth word
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_mrs_active) begin
            wsel_ff <= `FWF_SEL_E_LSB;
            rsel_ff <= `FWF_SEL_E_LSB;
        end else begin
            if (par_wr) wsel_ff <= wsel_ff + 2'h1;                  // [RULE_18]
            if (par_rd) rsel_ff <= rsel_ff + 2'h1;
        end
    end

    // readback word for the current read position, upper bits zero
    always_comb begin
        o_rd_word = '0;
        unique case (rsel_ff)
            `FWF_SEL_E_LSB: o_rd_word[`FWF_LSB_W-1:0] = empty_ff[`FWF_LSB_W-1:0];
            `FWF_SEL_E_MSB: o_rd_word[`FWF_MSB_W-1:0] = empty_ff[`FWF_OFF_W-1:`FWF_LSB_W];
            `FWF_SEL_F_LSB: o_rd_word[`FWF_LSB_W-1:0] = full_ff[`FWF_LSB_W-1:0];
            `FWF_SEL_F_MSB: o_rd_word[`FWF_MSB_W-1:0] = full_ff[`FWF_OFF_W-1:`FWF_LSB_W];
        endcase
    end

    assign o_empty_off = empty_ff;
    assign o_full_off  = full_ff;
endmodule : fwf_offset_regs
`default_nettype wire

// [fwf_flag_fifo.sv]
// What this block does
// [RULE_01] a word is stored on each write-clock rise while write strobe is low
// [RULE_02] output-ready goes low once the first word reaches an empty fifo; here only in fall-through mode, standard mode leaves it high
// [RULE_03] almost-empty goes high when the count reaches empty offset plus two
// [RULE_04] half-full goes low at half the depth plus two words
// [RULE_05] almost-full goes low at depth plus one minus full offset
// [RULE_06] input-ready goes high when full and further writes are dropped
// [RULE_07] capacity is memory depth plus the one output register word
// [RULE_08] reading a full fifo drops input-ready, later reads release the others
// [RULE_09] reading down, almost-empty goes low at empty offset plus one
// [RULE_10] after the last word output-ready goes high and reads are ignored
// [RULE_11] output-ready passes three register stages, input-ready two
// [RULE_12] load select and two picks at reset choose the default offset
// [RULE_13] deeper arrays use a table from 1,023 down to 7
// [RULE_14] load select high at reset means serial loading, low means parallel
// [RULE_15] offsets read back only through the parallel data output
// [RULE_16] offsets may be rewritten any time after reset, range 0 to depth-1
// [RULE_17] mode pin high at reset picks fall-through; first word shows after 3 edges
// [RULE_18] parallel offset words go empty lsb, empty msb, full lsb, full msb
// [RULE_19] serial loading shifts one bit per write-clock rise, empty lsb first
// [RULE_20] flags come from an occupancy counter compared with the offsets
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fwf_defines.svh"

module fwf_flag_fifo
    import fwf_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_wclk,
    input  wire logic         i_rclk,
    input  wire logic         i_wen_n,
    input  wire logic         i_ren_n,
    input  wire logic         i_offset_load_select,
    input  wire logic         i_serial_shift_strobe_n,
    input  wire logic         i_mode_or_serial_in,
    input  wire logic         i_default_offset_pick_1,
    input  wire logic         i_default_offset_pick_0,
    input  wire logic         i_master_reset_pulse_n,
    input  wire fwf_word_type i_data_in,
    output fwf_word_type      o_data_out_bus,
    output logic              o_write_room_flag_n,
    output logic              o_output_ready_n,
    output logic              o_half_full_flag_n,
    output logic              o_almost_full_flag_n,
    output logic              o_almost_empty_flag_n
);
    // ============================================================
    // helpers
    function automatic fwf_cnt_type fwf_ext(input fwf_off_type off);
        return {1'b0, off};
    endfunction : fwf_ext

    // words held, output register included
    function automatic fwf_cnt_type fwf_total(input fwf_cnt_type mem, input logic outv);
        return mem + {{(`FWF_CNT_W-1){1'b0}}, outv};               // [RULE_07] [RULE_20]
    endfunction : fwf_total

    // ============================================================
    // pin synchronisation
    logic [`FWF_SYNC_W-1:0] pins_raw;
    logic [`FWF_SYNC_W-1:0] pins_syn;
    logic                   wclk_s;
    logic                   rclk_s;
    logic                   wen_n_s;
    logic                   ren_n_s;
    logic                   ld_s;
    logic                   sen_n_s;
    logic                   si_s;
    logic                   pick1_s;
    logic                   pick0_s;
    logic                   mrs_n_s;
    fwf_word_type           data_s;

    assign pins_raw = {i_wclk, i_rclk, i_wen_n, i_ren_n, i_offset_load_select,
                       i_serial_shift_strobe_n, i_mode_or_serial_in,
                       i_default_offset_pick_1, i_default_offset_pick_0,
                       i_master_reset_pulse_n, i_data_in};

    fwf_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async (pins_raw),
        .o_sync  (pins_syn)
    );

    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, ld_s, sen_n_s, si_s,
            pick1_s, pick0_s, mrs_n_s, data_s} = pins_syn;

    // ============================================================
    // clock edge detection on the synchronised copies
    logic wclk_d_ff;
    logic rclk_d_ff;
    logic w_evt;
    logic r_evt;
    logic mrs_active;
    logic clr;

    // synchroniser resets low, so no false edge comes out of reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wclk_d_ff <= 1'b0;
            rclk_d_ff <= 1'b0;
        end else begin
            wclk_d_ff <= wclk_s;
            rclk_d_ff <= rclk_s;
        end
    end

    assign w_evt      = wclk_s & ~wclk_d_ff;
    assign r_evt      = rclk_s & ~rclk_d_ff;
    // pin honoured only after reset
    assign mrs_active = ~mrs_n_s & ~i_rst;
    assign clr        = i_rst | mrs_active;

    // ============================================================
    // timing mode, caught while master reset is held
    logic mode_ff;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mode_ff <= 1'b1;
        end else if (mrs_active) begin
            mode_ff <= si_s;                                        // [RULE_17]
        end
    end

    // ============================================================
    // programmable offsets
    fwf_off_type  empty_off;
    fwf_off_type  full_off;
    fwf_word_type off_word;

    fwf_offset_regs u_offs (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_mrs_active (mrs_active),
        .i_ld         (ld_s),
        .i_pick1      (pick1_s),
        .i_pick0      (pick0_s),
        .i_w_evt      (w_evt),
        .i_r_evt      (r_evt),
        .i_wen_n      (wen_n_s),
        .i_ren_n      (ren_n_s),
        .i_sen_n      (sen_n_s),
        .i_si         (si_s),
        .i_data       (data_s),
        .o_empty_off  (empty_off),
        .o_full_off   (full_off),
        .o_rd_word    (off_word)
    );

    // ============================================================
    // storage, pointers and occupancy
    fwf_word_type mem [0:(1<<`FWF_ADDR_W)-1];
    fwf_addr_type wr_ptr_ff;
    fwf_addr_type rd_ptr_ff;
    fwf_cnt_type  mem_cnt_ff;
    fwf_cnt_type  nxt_mem_cnt;
    fwf_cnt_type  total;
    logic         outv_ff;
    logic         or_p1_ff;
    logic         or_p2_ff;
    logic         ir_p1_ff;
    logic         ir_p2_ff;
    logic         mem_full;
    logic         mem_empty;
    logic         wr_acc;
    logic         rd_take;
    logic         fall;
    logic         pop;
    logic         off_rd;

    assign mem_full  = (mem_cnt_ff == `FWF_DEPTH);
    assign mem_empty = (mem_cnt_ff == '0);

    // writes dropped once the array is full
    assign wr_acc  = w_evt & ~wen_n_s & ld_s & ~mem_full;           // [RULE_01] [RULE_06]
    // in fall-through mode reads need a visible word; in standard mode any strobed read is taken
    assign rd_take = r_evt & ~ren_n_s & ld_s & (mode_ff ? (outv_ff & or_p2_ff) : 1'b1); // [RULE_10]
    // first word falls through, no strobe
    assign fall    = mode_ff & r_evt & ~outv_ff & ~mem_empty;       // [RULE_17]
    assign pop     = fall | (rd_take & ~mem_empty);
    assign off_rd  = r_evt & ~ren_n_s & ~ld_s;                      // [RULE_15]

    // array has no reset
    always_ff @(posedge i_mclk) begin
        if (wr_acc) begin
            mem[wr_ptr_ff] <= data_s;                               // [RULE_01]
        end
    end

    // pointers wrap naturally at the array size
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (wr_acc) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)    rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // write and pop in one cycle leave the count unchanged
    always_comb begin
        nxt_mem_cnt = mem_cnt_ff;
        if (wr_acc && !pop) nxt_mem_cnt = mem_cnt_ff + `FWF_ONE;    // [RULE_20]
        if (pop && !wr_acc) nxt_mem_cnt = mem_cnt_ff - `FWF_ONE;
    end

    always_ff @(posedge i_mclk) begin
        if (clr) begin
            mem_cnt_ff <= '0;
        end else begin
            mem_cnt_ff <= nxt_mem_cnt;
        end
    end

    // ============================================================
    // output register and its valid bit
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            outv_ff <= 1'b0;
        end else if (pop && mode_ff) begin
            outv_ff <= 1'b1;                                        // [RULE_07]
        end else if (rd_take && mem_empty) begin
            outv_ff <= 1'b0;                                        // [RULE_10]
        end
    end

    // fifo word or offset readback
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            o_data_out_bus <= '0;
        end else if (pop) begin
            o_data_out_bus <= mem[rd_ptr_ff];
        end else if (off_rd) begin
            o_data_out_bus <= off_word;                             // [RULE_15]
        end
    end

    // ============================================================
    // output-ready chain: valid bit plus two read-clock stages
    // emptying clears the chain so no second read is taken
    always_ff @(posedge i_mclk) begin
        if (clr || (rd_take && mem_empty)) begin
            or_p1_ff <= 1'b0;                                       // [RULE_10]
            or_p2_ff <= 1'b0;
        end else if (r_evt) begin
            or_p1_ff <= outv_ff;                                    // [RULE_11] [RULE_02]
            or_p2_ff <= or_p1_ff;
        end
    end

    assign o_output_ready_n = ~or_p2_ff;                            // [RULE_02]

    // ============================================================
    // input-ready chain: two write-clock stages of the full state
    // limitation: pin lags full by two write edges
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            ir_p1_ff <= 1'b0;
            ir_p2_ff <= 1'b0;
        end else if (w_evt) begin
            ir_p1_ff <= mem_full & (outv_ff | ~mode_ff);            // [RULE_06] [RULE_11]
            ir_p2_ff <= ir_p1_ff;                                   // [RULE_08]
        end
    end

    assign o_write_room_flag_n = ir_p2_ff;

    // ============================================================
    // threshold flags from the occupancy count
    assign total = fwf_total(mem_cnt_ff, outv_ff & mode_ff);

    always_ff @(posedge i_mclk) begin
        if (clr) begin
            o_almost_empty_flag_n <= 1'b0;
            o_half_full_flag_n    <= 1'b1;
            o_almost_full_flag_n  <= 1'b1;
        end else begin
            // high from n+2 words, low again at n+1 and below
            o_almost_empty_flag_n <= (total >= fwf_ext(empty_off) + `FWF_AE_GAP); // [RULE_03] [RULE_09]
            o_half_full_flag_n    <= (total < `FWF_HALF_MARK);      // [RULE_04] [RULE_08]
            o_almost_full_flag_n  <= (total < `FWF_CAP - fwf_ext(full_off));      // [RULE_05] [RULE_08]
        end
    end
endmodule : fwf_flag_fifo
`default_nettype wire

// [fwf_flag_fifo_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks for the flag fifo
module fwf_flag_fifo_asserts
    import fwf_pkg::*;
(
    input wire logic         i_mclk,
    input wire logic         i_rst,
    input wire logic         i_wclk,
    input wire logic         i_rclk,
    input wire logic         i_master_reset_pulse_n,
    input wire fwf_word_type o_data_out_bus,
    input wire logic         o_write_room_flag_n,
    input wire logic         o_output_ready_n,
    input wire logic         o_half_full_flag_n,
    input wire logic         o_almost_full_flag_n,
    input wire logic         o_almost_empty_flag_n
);
    logic       wq_ff, rq_ff;
    logic [3:0] w_age_ff, r_age_ff, q_age_ff;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_mclk) {wq_ff, rq_ff} <= {i_wclk, i_rclk};
    // cycles since a link clock rise; saturates so old edges never count
    always_ff @(posedge i_mclk) begin
        if (i_rst) w_age_ff <= 4'hf;
        else if (i_wclk && !wq_ff) w_age_ff <= 4'h0;
        else if (w_age_ff != 4'hf) w_age_ff <= w_age_ff + 4'h1;
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) r_age_ff <= 4'hf;
        else if (i_rclk && !rq_ff) r_age_ff <= 4'h0;
        else if (r_age_ff != 4'hf) r_age_ff <= r_age_ff + 4'h1;
    end
    // mask master reset, it moves flags with no clock
    always_ff @(posedge i_mclk) begin
        if (i_rst || !i_master_reset_pulse_n) q_age_ff <= 4'h0;
        else if (q_age_ff != 4'hf) q_age_ff <= q_age_ff + 4'h1;
    end
    chk_reset_values: assert property (disable iff (1'b0) i_rst |=>
        (!o_write_room_flag_n && o_output_ready_n && o_half_full_flag_n
         && o_almost_full_flag_n && !o_almost_empty_flag_n))
        else $error("flags after reset");
    chk_ae_needs_data: assert property (o_almost_empty_flag_n |-> !o_output_ready_n)
        else $error("ae high, no data");
    chk_af_implies_hf: assert property (!o_almost_full_flag_n |-> !o_half_full_flag_n)
        else $error("af without hf");
    chk_full_flag_set: assert property (o_write_room_flag_n |->
        (!o_almost_full_flag_n && !o_half_full_flag_n && o_almost_empty_flag_n))
        else $error("full flags");
    chk_flags_on_edge: assert property ((q_age_ff > 4'h4) &&
        $changed({o_half_full_flag_n, o_almost_full_flag_n, o_almost_empty_flag_n})
        |-> (w_age_ff <= 4'h8 || r_age_ff <= 4'h8))
        else $error("level flag off clock");
    chk_ready_on_rclk: assert property ((q_age_ff > 4'h4) && $fell(o_output_ready_n)
        |-> r_age_ff <= 4'h8)
        else $error("ready off rclk");
    chk_room_on_wclk: assert property ((q_age_ff > 4'h4) && $changed(o_write_room_flag_n)
        |-> w_age_ff <= 4'h8)
        else $error("room off wclk");
    chk_data_on_rclk: assert property ((q_age_ff > 4'h4) && $changed(o_data_out_bus)
        |-> r_age_ff <= 4'h8)
        else $error("data off rclk");
endmodule : fwf_flag_fifo_asserts

bind fwf_flag_fifo fwf_flag_fifo_asserts fwf_flag_fifo_asserts_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_wclk(i_wclk), .i_rclk(i_rclk),
    .i_master_reset_pulse_n(i_master_reset_pulse_n), .o_data_out_bus(o_data_out_bus),
    .o_write_room_flag_n(o_write_room_flag_n), .o_output_ready_n(o_output_ready_n),
    .o_half_full_flag_n(o_half_full_flag_n), .o_almost_full_flag_n(o_almost_full_flag_n),
    .o_almost_empty_flag_n(o_almost_empty_flag_n));
`default_nettype wire

// [fwf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host logic: link clocks, strobes, straps
module fwf_host_model
    import fwf_pkg::*;
(
    input  wire logic   i_mclk,
    output var logic    o_wclk,
    output var logic    o_rclk,
    output var logic    o_wen_n,
    output var logic    o_ren_n,
    output var logic    o_ld,
    output var logic    o_sen_n,
    output var logic    o_si,
    output var logic    o_pick1,
    output var logic    o_pick0,
    output var logic    o_mrs_n,
    output fwf_word_type o_data
);
    // idle levels at time zero
    initial begin
        {o_wclk, o_rclk, o_pick1, o_pick0} = 4'h0;
        {o_wen_n, o_ren_n, o_ld, o_sen_n, o_si, o_mrs_n} = 6'h3f;
        o_data = '0;
    end
    // free-running link clocks, phases apart
    always #40 o_wclk = ~o_wclk;
    initial begin
        #17;
        forever #40 o_rclk = ~o_rclk;
    end
    // master reset, straps held three write clocks
    task master_reset_pulse(input logic l, p1, p0);
        @(posedge i_mclk);
        {o_ld, o_pick1, o_pick0, o_si} <= {l, p1, p0, 1'b1};
        o_mrs_n <= 1'b0;
        repeat (3) @(posedge o_wclk);
        @(posedge i_mclk);
        o_mrs_n <= 1'b1;
        @(posedge o_wclk);
        @(posedge i_mclk);
    endtask : master_reset_pulse
    // k = {write, read, shift, load select}; held past the synced edge
    task op(input logic [3:0] k, input fwf_word_type d);
        if (k[2]) @(negedge o_rclk); else @(negedge o_wclk);
        @(posedge i_mclk);
        o_ld <= k[0];
        o_wen_n <= !k[3];
        o_ren_n <= !k[2];
        o_sen_n <= !k[1];
        o_si <= d[0];
        o_data <= d;
        if (k[2]) @(posedge o_rclk); else @(posedge o_wclk);
        repeat (4) @(posedge i_mclk);
        {o_wen_n, o_ren_n, o_sen_n, o_si} <= 4'hf;
        o_data <= ~d; // released
    endtask : op
endmodule : fwf_host_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench for the flag fifo
module testbench;
    import fwf_pkg::*;
    logic i_mclk, i_rst, wclk, rclk, wen_n, ren_n, ld, sen_n, si, p1, p0, mrs_n;
    logic room_n, or_n, hf_n, af_n, ae_n;
    fwf_word_type din, dout;
    int   mismatches = 0;
    int   comparisons = 0;
    fwf_off_type  dflt [8] = '{10'h07f, 10'h0ff, 10'h1ff, 10'h03f,
                               10'h01f, 10'h007, 10'h00f, 10'h003};
    fwf_word_type pw [4] = '{36'h003, 36'h000, 36'h02c, 36'h001};
    logic [19:0]  sb = {10'h064, 10'h005};

    fwf_flag_fifo fwf_flag_fifo_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_wclk(wclk),
        .i_rclk(rclk), .i_wen_n(wen_n), .i_ren_n(ren_n), .i_offset_load_select(ld),
        .i_serial_shift_strobe_n(sen_n), .i_mode_or_serial_in(si),
        .i_default_offset_pick_1(p1), .i_default_offset_pick_0(p0),
        .i_master_reset_pulse_n(mrs_n), .i_data_in(din), .o_data_out_bus(dout),
        .o_write_room_flag_n(room_n), .o_output_ready_n(or_n), .o_half_full_flag_n(hf_n),
        .o_almost_full_flag_n(af_n), .o_almost_empty_flag_n(ae_n));
    fwf_host_model fwf_host_model_inst (.i_mclk(i_mclk), .o_wclk(wclk), .o_rclk(rclk),
        .o_wen_n(wen_n), .o_ren_n(ren_n), .o_ld(ld), .o_sen_n(sen_n), .o_si(si),
        .o_pick1(p1), .o_pick0(p0), .o_mrs_n(mrs_n), .o_data(din));

    // 200 MHz system clock
    initial i_mclk = 1'b0;
    always #2.5 i_mclk = ~i_mclk;

    task stop_test();
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task chk_word(input fwf_word_type got, exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task chk_flags(input logic [2:0] got, exp);
        chk_word(36'(got), 36'(exp));
    endtask : chk_flags
    task chk_bit(input logic got, exp);
        chk_word(36'(got), 36'(exp));
    endtask : chk_bit
    // flags from occupancy, offsets n and m
    function logic [2:0] exp_fl(input int c, input int n, input int m);
        return {c < 514, c < 1025 - m, c >= n + 2};
    endfunction : exp_fl
    function fwf_word_type wd(input int i);
        return {20'ha5c3, i[15:0]};
    endfunction : wd
    // four offset readbacks in order
    task rd_offs(input fwf_off_type e, f);
        fwf_word_type w [4];
        w = '{36'(e[7:0]), 36'(e[9:8]), 36'(f[7:0]), 36'(f[9:8])};
        for (int k = 0; k < 4; k++) begin
            fwf_host_model_inst.op(4'h4, '0);
            repeat (8) @(posedge i_mclk);
            chk_word(dout, w[k]);
        end
    endtask : rd_offs

    // hang guard
    initial begin
        #450000;
        mismatches++;
        stop_test();
    end

    initial begin
        i_rst = 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            fwf_host_model_inst.master_reset_pulse(i[2], i[1], i[0]);
            chk_flags({hf_n, af_n, ae_n}, 3'b110);
            chk_bit(or_n, 1'b1);
            chk_bit(room_n, 1'b0);
            rd_offs(dflt[i], dflt[i]);
        end
        fwf_host_model_inst.master_reset_pulse(1'b0, 1'b0, 1'b0);
        foreach (pw[k]) fwf_host_model_inst.op(4'h8, pw[k]);
        rd_offs(10'h003, 10'h12c);
        fwf_host_model_inst.master_reset_pulse(1'b1, 1'b0, 1'b0);
        for (int k = 0; k < 20; k++) fwf_host_model_inst.op(4'h2, 36'(sb[k]));
        rd_offs(10'h005, 10'h064);
        foreach (pw[k]) fwf_host_model_inst.op(4'h8, pw[k]);
        rd_offs(10'h005, 10'h064);
        // fill; last write is dropped
        for (int i = 1; i <= 1026; i++) begin
            fwf_host_model_inst.op(4'h9, wd(i));
            repeat (8) @(posedge i_mclk);
            chk_flags({hf_n, af_n, ae_n}, exp_fl(i > 1025 ? 1025 : i, 5, 100));
            if (i == 1024) chk_bit(room_n, 1'b0);
            if (i == 1) begin
                chk_bit(or_n, 1'b1);
                repeat (4) @(posedge rclk);
                repeat (8) @(posedge i_mclk);
                chk_bit(or_n, 1'b0);
                chk_word(dout, wd(1));
            end
        end
        repeat (2) @(posedge wclk);
        repeat (8) @(posedge i_mclk);
        chk_bit(room_n, 1'b1);
        // drain, one read past empty
        for (int i = 1; i <= 1026; i++) begin
            fwf_host_model_inst.op(4'h5, '0);
            repeat (8) @(posedge i_mclk);
            chk_flags({hf_n, af_n, ae_n}, exp_fl(i > 1025 ? 0 : 1025 - i, 5, 100));
            chk_bit(or_n, i < 1025 ? 1'b0 : 1'b1);
            if (i < 1025) chk_word(dout, wd(i + 1));
            if (i == 1) begin
                repeat (3) @(posedge wclk);
                repeat (8) @(posedge i_mclk);
                chk_bit(room_n, 1'b0);
            end
        end
        stop_test();
    end
endmodule : testbench
`default_nettype wire
